// ==== verilog/ecac_top.sv ====
// external cache access control: write pulse shaping, bypass, burst read timing
// Functional notes
// - fifteen bit write pulse shape field
// - field bit 0 governs second write cycle
// - no write enable in first cycle
// - size code 000 128KB up to 16MB
// - tag control parity corrupted on writes
// - one bypass bit per address quadrant
// - bypass skips probe, system request immediately
// - bypass leaves primary cacheability to system
// - invert check bits 0,7,14,21 on writes
// - wrapped read return order, reset clears
// - zero burst field uses read speed
// - 128-bit second half takes field+1
// - 64-bit reads 2,4 (3 if all) field+1
module ecac_top
   import ecac_pkg::*;
(
   input  wire logic              i_clock,
   input  wire logic              i_sys_rst,
   input  wire logic [1:0]        i_addr,
   input  wire logic [31:0]       i_wdata,
   input  wire logic              i_wr,
   input  wire logic              i_rd,
   output logic      [31:0]       o_rdata,
   input  wire logic              i_ref_valid,
   input  wire logic              i_ref_write,
   input  wire logic [33:0]       i_ref_pa,
   input  wire logic              i_wide_mode,
   input  wire logic [CHK_W-1:0]  i_chk,
   input  wire logic              i_tag_ctl_par,
   input  wire logic              i_read_ack_field,
   output logic                   o_busy,
   output logic                   o_sys_req,
   output logic                   o_probe,
   output logic                   o_we,
   output logic                   o_ce,
   output logic [CHK_W-1:0]       o_chk,
   output logic                   o_tag_ctl_par,
   output logic                   o_rd_sample,
   output logic                   o_rd_done,
   output logic                   o_wrap_order,
   output logic                   o_primary_cacheable,
   output logic [4:0]             o_size_log2
);
   logic [CTL_W-1:0]   ctl;
   ecac_state_t        state_q;
   logic [3:0]         cnt_q;
   logic [3:0]         len_q;
   logic [1:0]         beat_q;
   logic [3:0]         wcyc_q;
   logic               use_cache;
   logic [WE_W-1:0]    we_shape;
   logic [SPD_W-1:0]   rd_spd;
   logic [SPD_W-1:0]   wr_spd;
   logic [BURST_W-1:0] burst;
   logic               start;
   logic               ack_meta_q;
   logic               ack_sync_q;

   ecac_cfg_reg u_cfg (
      .i_clock   (i_clock),
      .i_sys_rst (i_sys_rst),
      .i_addr    (i_addr),
      .i_wdata   (i_wdata),
      .i_wr      (i_wr),
      .o_ctl     (ctl)
   );

   assign we_shape = ctl[WE_LSB +: WE_W];
   assign rd_spd   = ctl[RD_SPD_LSB +: SPD_W];
   assign wr_spd   = ctl[WR_SPD_LSB +: SPD_W];
   assign burst    = ctl[BURST_LSB +: BURST_W];

   // cache use per reference from enable and quadrant bits
   function automatic logic cache_used(input logic [CTL_W-1:0] c, input logic [1:0] q);
      cache_used = c[ENA_BIT] && !c[QB_LSB + int'(q)];
   endfunction

   // beat length: burst timing on selected beats, else read speed
   function automatic logic [3:0] beat_len(input logic [1:0] b, input logic wide,
                                           input logic all, input logic [BURST_W-1:0] bs,
                                           input logic [SPD_W-1:0] rs);
      logic fast;
      fast = 1'b0;
      if (bs != '0) begin
         if (wide) fast = (b == 2'h1);
         else fast = (b == 2'h1) || (b == 2'h3) || (all && b == 2'h2);
      end
      beat_len = fast ? {1'b0, bs} : rs;
   endfunction

   assign use_cache = cache_used(ctl, i_ref_pa[33:32]);
   assign start     = i_ref_valid && state_q == ECAC_IDLE;
   assign o_busy    = state_q != ECAC_IDLE;
   // bypassed references go to the system without a probe
   assign o_sys_req = start && !use_cache;
   assign o_probe   = start && use_cache;
   // primary cacheability follows the system answer only
   assign o_primary_cacheable = ack_sync_q;
   assign o_wrap_order = ctl[WRAP_BIT];
   assign o_size_log2  = SIZE_BASE_LOG2 + {2'h0, ctl[SIZE_LSB +: SIZE_W]};
   assign o_rdata      = 32'h0;

   // two-stage synchroniser for the system acknowledge pin
   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         ack_meta_q <= 1'b0;
         ack_sync_q <= 1'b0;
      end else begin
         ack_meta_q <= i_read_ack_field;
         ack_sync_q <= ack_meta_q;
      end
   end

   // access sequencer state
   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         state_q <= ECAC_IDLE;
      end else begin
         case (state_q)
            ECAC_IDLE: begin
               if (o_probe && i_ref_write) begin
                  state_q <= ECAC_WRITE;
               end else if (o_probe) begin
                  state_q <= ECAC_READ;
               end
            end
            ECAC_WRITE: begin
               if (cnt_q == 4'h0) begin
                  state_q <= ECAC_IDLE;
               end
            end
            ECAC_READ: begin
               if (cnt_q == 4'h0 && beat_q == len_q[1:0]) begin
                  state_q <= ECAC_IDLE;
               end
            end
            default: begin
               state_q <= ECAC_IDLE;
            end
         endcase
      end
   end

   // cycle counter of the write or of the current read beat
   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         cnt_q <= 4'h0;
      end else if (o_probe) begin
         cnt_q <= i_ref_write ? wr_spd : rd_spd;
      end else if (state_q != ECAC_IDLE && cnt_q != 4'h0) begin
         cnt_q <= cnt_q - 4'h1;
      end else if (state_q == ECAC_READ && beat_q != len_q[1:0]) begin
         cnt_q <= beat_len(beat_q + 2'h1, i_wide_mode, ctl[BURST_ALL_BIT], burst, rd_spd);
      end
   end

   // read beat index
   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         beat_q <= 2'h0;
      end else if (o_probe) begin
         beat_q <= 2'h0;
      end else if (state_q == ECAC_READ && cnt_q == 4'h0 && beat_q != len_q[1:0]) begin
         beat_q <= beat_q + 2'h1;
      end
   end

   // index of the last read beat
   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         len_q <= 4'h0;
      end else if (o_probe && !i_ref_write) begin
         len_q <= i_wide_mode ? 4'h1 : 4'h3;
      end
   end

   // cycle index within a write access
   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         wcyc_q <= 4'h0;
      end else if (o_probe) begin
         wcyc_q <= 4'h0;
      end else if (state_q == ECAC_WRITE) begin
         wcyc_q <= wcyc_q + 4'h1;
      end
   end

   // write pulse shaping per cycle of the access
   always_comb begin
      o_we = 1'b0;
      if (state_q == ECAC_WRITE && wcyc_q != 4'h0) begin
         o_we = we_shape[wcyc_q - 4'h1];
      end
   end
   assign o_ce = o_we && !ctl[OE_BIT];
   assign o_rd_sample = state_q == ECAC_READ && cnt_q == 4'h0;
   assign o_rd_done   = o_rd_sample && beat_q == len_q[1:0];

   // diagnostic corruption of outgoing check and tag control parity
   assign o_chk = ctl[DP_BIT] ? (i_chk ^ CHK_FLIP) : i_chk;
   assign o_tag_ctl_par = i_tag_ctl_par ^ ctl[TCP_BIT];

   quadrant_bypass_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
      (start && ctl[QB_LSB + int'(i_ref_pa[33:32])]) |-> o_sys_req && !o_probe)
      else $error("disabled quadrant used cache");
   bypass_enable_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
      (start && !ctl[ENA_BIT]) |-> o_sys_req ##1 state_q == ECAC_IDLE)
      else $error("disabled cache probed");
   first_cycle_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
      (o_probe && i_ref_write) |=> !o_we)
      else $error("write enable in first cycle");
   second_cycle_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
      (o_probe && i_ref_write && wr_spd != 4'h0 && !i_wr) |=> ##1 o_we == ctl[WE_LSB])
      else $error("second cycle enable mismatch");
   check_flip_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
      ctl[DP_BIT] |-> (o_chk[0] != i_chk[0] && o_chk[21] != i_chk[21]
                       && o_chk[1] == i_chk[1]))
      else $error("check bit inversion wrong");
   tag_parity_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
      ctl[TCP_BIT] |-> o_tag_ctl_par != i_tag_ctl_par)
      else $error("tag parity not corrupted");
   size_code_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
      ctl[SIZE_LSB +: SIZE_W] == 3'h7 |-> o_size_log2 == 5'h18)
      else $error("size decode wrong");
   read_no_burst_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
      (o_probe && !i_ref_write && burst == 3'h0 && rd_spd == 4'h3 && !i_wr)
      |=> !o_rd_sample [*3] ##1 o_rd_sample ##1 !o_rd_sample)
      else $error("read beat timing wrong");
   burst_wide_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
      (o_rd_sample && beat_q == 2'h0 && i_wide_mode && burst == 3'h1 && !i_wr)
      |=> !o_rd_sample ##1 o_rd_sample)
      else $error("128-bit second half timing wrong");
   burst_narrow_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
      (o_rd_sample && beat_q == 2'h2 && !i_wide_mode && burst == 3'h2 && !i_wr)
      |=> !o_rd_sample [*2] ##1 o_rd_sample)
      else $error("64-bit fourth read timing wrong");
   wrap_reset_a: assert property (@(posedge i_clock)
      $fell(i_sys_rst) |-> !o_wrap_order)
      else $error("wrap bit not cleared by reset");

   // write pulse checks
   we_idle_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
      !o_busy |-> !o_we && !o_ce)
      else $error("write enable while idle");
   ce_follow_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
      o_ce |-> o_we)
      else $error("chip enable without write enable");
   write_len_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
      (o_probe && i_ref_write && wr_spd == 4'h3 && !i_wr) |=> o_busy [*4] ##1 !o_busy)
      else $error("write access length wrong");
   third_cycle_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
      (o_probe && i_ref_write && wr_spd == 4'h3 && !i_wr) |=> ##2 o_we == ctl[WE_LSB + 1])
      else $error("third cycle enable mismatch");

   // size decode checks
   size_base_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
      ctl[SIZE_LSB +: SIZE_W] == 3'h0 |-> o_size_log2 == 5'h11)
      else $error("smallest size decode wrong");
   size_four_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
      ctl[SIZE_LSB +: SIZE_W] == 3'h4 |-> o_size_log2 == 5'h15)
      else $error("middle size decode wrong");

   // diagnostic corruption checks
   check_clean_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
      !ctl[DP_BIT] |-> o_chk == i_chk)
      else $error("check bits altered");
   check_mid_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
      ctl[DP_BIT] |-> o_chk[7] != i_chk[7] && o_chk[14] != i_chk[14])
      else $error("middle check bits not inverted");
   tag_clean_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
      !ctl[TCP_BIT] |-> o_tag_ctl_par == i_tag_ctl_par)
      else $error("tag parity altered");

   // cache use checks
   probe_excl_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
      !(o_probe && o_sys_req))
      else $error("probe and system request together");
   enabled_probe_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
      (start && ctl[ENA_BIT] && !ctl[QB_LSB + int'(i_ref_pa[33:32])]) |-> o_probe)
      else $error("enabled quadrant not probed");
   ack_sync_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
      o_primary_cacheable == $past(i_read_ack_field, 2))
      else $error("primary cacheability not from system");

   // burst read checks
   burst_all_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
      (o_rd_sample && beat_q == 2'h1 && !i_wide_mode && ctl[BURST_ALL_BIT]
       && burst == 3'h1 && !i_wr)
      |=> !o_rd_sample ##1 o_rd_sample)
      else $error("64-bit third read timing wrong");
   second_narrow_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
      (o_rd_sample && beat_q == 2'h0 && !i_wide_mode && burst == 3'h2 && !i_wr)
      |=> !o_rd_sample [*2] ##1 o_rd_sample)
      else $error("64-bit second read timing wrong");
   wide_done_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
      (o_rd_sample && beat_q == 2'h1 && i_wide_mode) |-> o_rd_done)
      else $error("128-bit read not done after two halves");
endmodule

// ==== verilog/ecac_pkg.sv ====
// package: field layout and constants of the external cache access control
package ecac_pkg;
   localparam int CTL_W          = 64;
   localparam int ENA_BIT        = 0;
   localparam int ECC_BIT        = 1;
   localparam int OE_BIT         = 2;
   localparam int FHIT_BIT       = 3;
   localparam int RD_SPD_LSB     = 4;
   localparam int WR_SPD_LSB     = 8;
   localparam int SPD_W          = 4;
   localparam int WE_LSB         = 13;
   localparam int WE_W           = 15;
   localparam int SIZE_LSB       = 28;
   localparam int SIZE_W         = 3;
   localparam int TCP_BIT        = 31;
   localparam int QB_LSB         = 32;
   localparam int QB_W           = 4;
   localparam int DP_BIT         = 36;
   localparam int WRAP_BIT       = 37;
   localparam int BURST_ALL_BIT  = 38;
   localparam int BURST_LSB      = 40;
   localparam int BURST_W        = 3;
   localparam int CHK_W          = 28;
   localparam logic [27:0] CHK_FLIP = 28'h0204081;
   localparam logic [CTL_W-1:0] CTL_RST = 64'h0;
   localparam logic [1:0] ADDR_LO   = 2'h0;
   localparam logic [1:0] ADDR_HI   = 2'h1;
   localparam logic [4:0] SIZE_BASE_LOG2 = 5'h11;
   typedef enum logic [1:0] {ECAC_IDLE, ECAC_WRITE, ECAC_READ} ecac_state_t;
endpackage

// ==== verilog/ecac_cfg_reg.sv ====
// write-only control register, loaded in two 32-bit halves
module ecac_cfg_reg
   import ecac_pkg::*;
(
   input  wire logic             i_clock,
   input  wire logic             i_sys_rst,
   input  wire logic [1:0]       i_addr,
   input  wire logic [31:0]      i_wdata,
   input  wire logic             i_wr,
   output logic      [CTL_W-1:0] o_ctl
);
   logic [CTL_W-1:0] ctl_q;

   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         ctl_q <= CTL_RST;
      end else if (i_wr && i_addr == ADDR_LO) begin
         ctl_q[31:0] <= i_wdata;
      end else if (i_wr && i_addr == ADDR_HI) begin
         ctl_q[63:32] <= i_wdata;
      end
   end

   assign o_ctl = ctl_q;
endmodule

// ==== bench/ecac_far_model.sv ====
// far side model: system bus logic answering bypassed requests
module ecac_far_model (
   input  wire logic i_clock,
   input  wire logic i_sys_rst,
   input  wire logic i_sys_req,
   input  wire logic i_wrap_order,
   output logic      o_read_ack_field,
   output logic      o_wrapped
);
   timeunit 1ns;
   timeprecision 1ns;
   // system alone decides primary cacheability, flips per request
   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst)
         o_read_ack_field <= 1'b0;
      else if (i_sys_req)
         o_read_ack_field <= ~o_read_ack_field;
   end
   assign o_wrapped = i_wrap_order;
endmodule

// ==== bench/test_ext_cache_access_control.sv ====
// testbench: register writes, references, cycle checks
module test_ext_cache_access_control;
   timeunit 1ns;
   timeprecision 1ns;
   import ecac_pkg::*;
   logic i_clock = 0, i_sys_rst = 1, i_wr = 0, i_rd = 0, i_ref_valid = 0, i_ref_write = 0;
   logic [1:0] i_addr = 0;
   logic [31:0] i_wdata = 0, o_rdata;
   logic [33:0] i_ref_pa = 0;
   logic i_wide_mode = 1, i_tag_ctl_par = 1, ack, wrapped, exp_ack;
   logic [CHK_W-1:0] i_chk = 28'h5a5a5a5, o_chk;
   logic o_busy, o_sys_req, o_probe, o_we, o_ce, o_tag_ctl_par, o_rd_sample, o_rd_done;
   logic o_wrap_order, o_primary_cacheable;
   logic [4:0] o_size_log2;
   logic [1:0] ps;
   logic [63:0] we;
   int n_errors = 0, n_tests = 0, n;
   int tbl [5][4] = '{'{1,0,1,6}, '{0,0,2,14}, '{0,1,1,10}, '{1,0,0,8}, '{0,0,0,16}};
   always #20 i_clock = ~i_clock;
   ecac_top i_ecac_top (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_addr(i_addr),
      .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
      .i_ref_valid(i_ref_valid), .i_ref_write(i_ref_write), .i_ref_pa(i_ref_pa),
      .i_wide_mode(i_wide_mode), .i_chk(i_chk), .i_tag_ctl_par(i_tag_ctl_par),
      .i_read_ack_field(ack), .o_busy(o_busy), .o_sys_req(o_sys_req), .o_probe(o_probe),
      .o_we(o_we), .o_ce(o_ce), .o_chk(o_chk), .o_tag_ctl_par(o_tag_ctl_par),
      .o_rd_sample(o_rd_sample), .o_rd_done(o_rd_done), .o_wrap_order(o_wrap_order),
      .o_primary_cacheable(o_primary_cacheable), .o_size_log2(o_size_log2));
   ecac_far_model i_ecac_far_model (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
      .i_sys_req(o_sys_req), .i_wrap_order(o_wrap_order), .o_read_ack_field(ack),
      .o_wrapped(wrapped));
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic reg_wr(input logic [1:0] a, input logic [31:0] d);
      @(posedge i_clock);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_clock);
      i_wr <= 1'b0;
      #1;
   endtask
   task automatic ref_go(input logic wr, input logic [1:0] q);
      @(posedge i_clock);
      i_ref_valid <= 1'b1;
      i_ref_write <= wr;
      i_ref_pa <= {q, 32'h100};
      #1 ps = {o_probe, o_sys_req};
      @(posedge i_clock);
      i_ref_valid <= 1'b0;
      n = 0;
      we = '0;
      #1;
      while (o_busy === 1'b1 && n < 40) begin
         we[n] = o_we;
         n++;
         check("ce", o_ce, o_we);
         if (o_rd_done === 1'b1)
            break;
         @(posedge i_clock);
         #1;
      end
      if (n == 40) check("busy", o_busy, 0);
   endtask
   task automatic finish_test;
      if (n_errors == 0 && n_tests > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   initial begin
      #100000 n_errors++;
      finish_test;
   end
   initial begin
      repeat (6) @(posedge i_clock);
      i_sys_rst <= 1'b0;
      #1 check("size", o_size_log2, 17);
      @(posedge i_clock);
      i_rd <= 1'b1;
      @(posedge i_clock);
      i_rd <= 1'b0;
      #1 check("rdata", o_rdata, 0);
      for (int c = 0; c < 8; c++) begin
         reg_wr(0, c << 28);
         check("size", o_size_log2, 17 + c);
      end
      reg_wr(0, 32'h0000a331);
      ref_go(1, 0);
      check("we", we[3:0], 4'b1010);
      check("chk", o_chk, i_chk);
      reg_wr(1, 32'h10);
      check("chk", o_chk, i_chk ^ CHK_FLIP);
      reg_wr(0, 32'h8000a331);
      check("tcp", o_tag_ctl_par, 0);
      reg_wr(1, 32'h20);
      check("wrap", {o_wrap_order, wrapped}, 2'b11);
      exp_ack = 0;
      for (int q = 0; q < 4; q++) begin
         reg_wr(1, 1 << q);
         ref_go(0, q[1:0]);
         check("bypass", ps, 2'b01);
         exp_ack = ~exp_ack;
         repeat (2) @(posedge i_clock);
         #1;
         check("pcache", o_primary_cacheable, exp_ack);
         ref_go(0, q[1:0] + 2'h1);
         check("probe", ps, 2'b10);
      end
      reg_wr(0, 32'h0000a330);
      ref_go(0, 0);
      check("noena", ps, 2'b01);
      reg_wr(0, 32'h0000a331);
      for (int t = 0; t < 5; t++) begin
         i_wide_mode <= tbl[t][0][0];
         reg_wr(1, (tbl[t][2] << 8) | (tbl[t][1] << 6));
         ref_go(0, 0);
         check("cycles", n, tbl[t][3]);
      end
      reg_wr(1, 32'h20);
      i_sys_rst <= 1'b1;
      @(posedge i_clock);
      i_sys_rst <= 1'b0;
      #1 check("wrap", o_wrap_order, 0);
      finish_test;
   end
endmodule
